/* design/pei_pkg.sv */
// Functional notes
// - any pin or pin combination raises change interrupt
// - master enable gates irq, detection continues
// - per-pin rising detector armed by rise enable
// - per-pin falling detector armed by fall enable
// - both enables detect both edge polarities
// - enabled edge sets pin flag
// - summary flag is OR of pin flags
// - software clears flag by writing zero
// - edge during clear leaves flag set
// - change event wakes from sleep when enabled
// - rise enables bits 5:0, bits 7:6 zero
// - fall enables bits 5:0, bits 7:6 zero
// - all edge enables reset to zero
// - port A flags bits 5:0, reset zero
// - debugger blocks change detect on pins 1,0
`default_nettype none
package pei_pkg;
  localparam int PEI_PINS = 6;
  localparam logic [7:0] PEI_IMPL_MASK = 8'h3F;
  localparam logic [7:0] PEI_DBG_MASK = 8'h03;
  localparam logic [7:0] PEI_RESET_VAL = 8'h00;
  // edges after reset ignored until the synchroniser has settled
  localparam logic [2:0] PEI_PRIME_CYC = 3'h5;
  // word offsets (byte addresses)
  localparam logic [7:0] PEI_OFS_RISE = 8'h00;
  localparam logic [7:0] PEI_OFS_FALL = 8'h04;
  localparam logic [7:0] PEI_OFS_FLAG = 8'h08;
  localparam logic [7:0] PEI_OFS_CTRL = 8'h0C;
  localparam logic [7:0] PEI_OFS_STAT = 8'h10;
  localparam logic [7:0] PEI_OFS_SCLR = 8'h14;
  localparam logic [7:0] PEI_OFS_SEN = 8'h18;
  // control register fields
  localparam int PEI_CTRL_MASTER = 0;
  // event status bits
  localparam int PEI_EV_EDGE = 0;
  localparam int PEI_EV_WAKE = 1;
  localparam int PEI_EV_W = 2;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pei_wb_req_t;
endpackage
`default_nettype wire

/* design/pei_sync.sv */
`default_nettype none
module pei_sync
  import pei_pkg::*;
#(
  parameter int W = 6
) (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] stable;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          stable[g] <= 1'b0;
        end else if (ce_i) begin
          s1[g] <= d_i[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            stable[g] <= s3[g];
          end
        end
      end
    end
  endgenerate
  assign q_o = stable;
endmodule
`default_nettype wire

/* design/pei_edge.sv */
`default_nettype none
module pei_edge
  import pei_pkg::*;
#(
  parameter int W = 6
) (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pins and enables
  input wire logic [W-1:0] pin_i,
  input wire logic [W-1:0] rise_en_i,
  input wire logic [W-1:0] fall_en_i,
  output logic [W-1:0] hit_o
);
  logic [W-1:0] prev;
  logic [2:0] settle;
  // a pin idling high must not look like a rising edge while the synchroniser refills
  wire primed = (settle == PEI_PRIME_CYC);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= '0;
      settle <= 3'h0;
    end else if (ce_i) begin
      prev <= pin_i;
      if (!primed) begin
        settle <= settle + 3'h1;
      end
    end
  end
  wire [W-1:0] rose = pin_i & ~prev & {W{primed}};
  wire [W-1:0] fell = ~pin_i & prev & {W{primed}};
  assign hit_o = ((rose & rise_en_i) | (fell & fall_en_i)) & {W{ce_i}};
endmodule
`default_nettype wire

/* design/pei_top.sv */
// Decided for this implementation: register access over Wishbone and the register addresses.
`default_nettype none
module pei_top
  import pei_pkg::*;
#(
  parameter int PINS = PEI_PINS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins and system
  input wire logic [PINS-1:0] pin_i,
  input wire logic debug_en_i,
  input wire logic sleep_i,
  output logic wake_o,
  output logic summary_flag_o,
  output logic irq_o,
  output logic evt_irq_o
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] port_a_rising_edge_enable;
  logic [7:0] port_a_falling_edge_enable;
  logic [7:0] port_a_change_flag;
  logic change_irq_master_enable;
  logic [PEI_EV_W-1:0] evt_status;
  logic [PEI_EV_W-1:0] evt_enable;
  logic [31:0] rdata;
  logic ack;
  logic wake;
  pei_wb_req_t req;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire acc = req.cyc & req.stb & ~ack & ce_i;
  wire wr_b0 = acc & req.we & req.sel[0];
  wire wr_rise = wr_b0 & (req.adr == PEI_OFS_RISE);
  wire wr_fall = wr_b0 & (req.adr == PEI_OFS_FALL);
  wire wr_flag = wr_b0 & (req.adr == PEI_OFS_FLAG);
  wire wr_ctrl = wr_b0 & (req.adr == PEI_OFS_CTRL);
  wire wr_sclr = wr_b0 & (req.adr == PEI_OFS_SCLR);
  wire wr_sen = wr_b0 & (req.adr == PEI_OFS_SEN);
  wire [7:0] impl = PEI_IMPL_MASK & ~(debug_en_i ? PEI_DBG_MASK : 8'h00);
  wire [31:0] rd_mux =
    (req.adr == PEI_OFS_RISE) ? {24'h000000, port_a_rising_edge_enable} :
    (req.adr == PEI_OFS_FALL) ? {24'h000000, port_a_falling_edge_enable} :
    (req.adr == PEI_OFS_FLAG) ? {24'h000000, port_a_change_flag} :
    (req.adr == PEI_OFS_CTRL) ? {31'h0, change_irq_master_enable} :
    (req.adr == PEI_OFS_STAT) ? {30'h0, evt_status} :
    (req.adr == PEI_OFS_SEN) ? {30'h0, evt_enable} :
    32'h00000000;

  // ------------------------------------------------------------
  // pin path
  // ------------------------------------------------------------
  logic [PINS-1:0] pin_s;
  logic [PINS-1:0] hit;
  pei_sync #(.W(PINS)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(pin_i),
    .q_o(pin_s)
  );
  pei_edge #(.W(PINS)) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(pin_s),
    .rise_en_i(port_a_rising_edge_enable[PINS-1:0] & impl[PINS-1:0]),
    .fall_en_i(port_a_falling_edge_enable[PINS-1:0] & impl[PINS-1:0]),
    .hit_o(hit)
  );
  wire [7:0] set8 = {{(8-PINS){1'b0}}, hit} & impl;
  // write of zero clears, a same-cycle set wins
  wire [7:0] next_flag = ((wr_flag ? (port_a_change_flag & req.dat[7:0]) : port_a_change_flag) | set8)
    & PEI_IMPL_MASK;
  wire summary = |port_a_change_flag;
  wire change_irq = summary & change_irq_master_enable;
  wire next_wake = sleep_i & change_irq;
  wire [PEI_EV_W-1:0] ev = {next_wake & ~wake, |set8};
  wire [PEI_EV_W-1:0] next_evt = (wr_sclr ? (evt_status & ~req.dat[PEI_EV_W-1:0]) : evt_status) | ev;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_rising_edge_enable <= PEI_RESET_VAL;
      port_a_falling_edge_enable <= PEI_RESET_VAL;
      port_a_change_flag <= PEI_RESET_VAL;
      change_irq_master_enable <= 1'b0;
      evt_status <= '0;
      evt_enable <= '0;
      rdata <= '0;
      ack <= 1'b0;
      wake <= 1'b0;
    end else if (ce_i) begin
      if (wr_rise) port_a_rising_edge_enable <= req.dat[7:0] & PEI_IMPL_MASK;
      if (wr_fall) port_a_falling_edge_enable <= req.dat[7:0] & PEI_IMPL_MASK;
      if (wr_ctrl) change_irq_master_enable <= req.dat[PEI_CTRL_MASTER];
      if (wr_sen) evt_enable <= req.dat[PEI_EV_W-1:0];
      port_a_change_flag <= next_flag;
      evt_status <= next_evt;
      wake <= next_wake;
      ack <= acc;
      if (acc) rdata <= rd_mux;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign summary_flag_o = summary;
  assign irq_o = change_irq;
  assign wake_o = wake;
  assign evt_irq_o = |(evt_status & evt_enable);
endmodule
`default_nettype wire

/* tb/pei_asserts.sv */
`default_nettype none
module pei_asserts (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // system
  input wire logic sleep_i,
  input wire logic wake_o,
  input wire logic summary_flag_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  AST_ACK: assert property (s_req |=> s_ans) else $error("ack not one cycle pulse after request");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack without request");
  AST_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack while idle");
  AST_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:6] == 26'h0) else $error("upper bits set");
  AST_IRQ: assert property (irq_o |-> summary_flag_o) else $error("irq without flag");
  AST_WAKE: assert property (ce_i && sleep_i && irq_o |=> wake_o) else $error("no wake");
  AST_WAKE_CAUSE: assert property (wake_o |-> $past(sleep_i) && $past(summary_flag_o)) else $error("stray wake");
  AST_RST_FLAG: assert property ($past(rst_i) |-> !summary_flag_o) else $error("flag after reset");
  AST_STICKY: assert property (ce_i && summary_flag_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> summary_flag_o)
    else $error("flag lost without write");
  AST_FREEZE: assert property (!ce_i |=> $stable(summary_flag_o) && $stable(wake_o) && $stable(irq_o)
    && $stable(wb_ack_o) && $stable(wb_dat_o)) else $error("state moved while clock enable low");
endmodule
bind pei_top pei_asserts u_ast (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
  .wake_o(wake_o), .summary_flag_o(summary_flag_o), .irq_o(irq_o));
`default_nettype wire

/* tb/pei_pins.sv */
`default_nettype none
module pei_pins (
  // clock
  input wire logic clk_i,
  // pins
  input wire logic [5:0] want_i,
  output logic [5:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 6'h00;
  // pins take the requested level one cycle after it is asked for
  always @(posedge clk_i) pin_o <= want_i;
endmodule
`default_nettype wire

/* tb/pin_edge_interrupt_detector_bench.sv */
`default_nettype none
module pin_edge_interrupt_detector_bench;
  import pei_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, ce = 1'b1, dbg = 1'b0, slp = 1'b0, ack, wake, sum, irq, evt;
  pei_wb_req_t q = '0;
  logic [5:0] want = 6'h00, pin;
  logic [31:0] rdat, got;
  logic [7:0] ofs [6] = '{PEI_OFS_RISE, PEI_OFS_FALL, PEI_OFS_FLAG, PEI_OFS_CTRL, PEI_OFS_STAT, PEI_OFS_SEN};
  int err_total = 0, n_compared = 0, cyc_n = 0;
  always #25 clk_i = ~clk_i;
  pei_pins PM (.clk_i(clk_i), .want_i(want), .pin_o(pin));
  pei_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(q.cyc), .wb_stb_i(q.stb), .wb_we_i(q.we),
    .wb_adr_i(q.adr), .wb_sel_i(q.sel), .wb_dat_i(q.dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin),
    .debug_en_i(dbg), .sleep_i(slp), .wake_o(wake), .summary_flag_o(sum), .irq_o(irq), .evt_irq_o(evt));
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    q <= '{1'b1, 1'b1, w, a, s, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    got = rdat;
    q <= '0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg%h", a), e, got);
  endtask
  task automatic pins(input logic [5:0] v);
    want <= v;
    repeat (8) @(posedge clk_i);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) rc(ofs[i], 32'h0);
    bus(1'b1, PEI_OFS_RISE, 32'hFF);
    bus(1'b1, PEI_OFS_FALL, 32'hFF);
    rc(PEI_OFS_RISE, 32'h3F);
    rc(PEI_OFS_FALL, 32'h3F);
    bus(1'b1, PEI_OFS_FALL, 32'h0);
    bus(1'b1, PEI_OFS_SEN, 32'h1);
    bus(1'b1, 8'h1C, 32'hFF);
    rc(8'h1C, 32'h0);
    pins(6'h3F);
    rc(PEI_OFS_FLAG, 32'h3F);
    chk("irq", 32'h0, irq);
    chk("sum", 32'h1, sum);
    chk("evt", 32'h1, evt);
    rc(PEI_OFS_STAT, 32'h1);
    bus(1'b1, PEI_OFS_SCLR, 32'h3);
    rc(PEI_OFS_STAT, 32'h0);
    chk("evt", 32'h0, evt);
    bus(1'b1, PEI_OFS_FLAG, 32'h3E);
    rc(PEI_OFS_FLAG, 32'h3E);
    pins(6'h00);
    rc(PEI_OFS_FLAG, 32'h3E);
    bus(1'b1, PEI_OFS_FLAG, 32'h0);
    chk("sum", 32'h0, sum);
    bus(1'b1, PEI_OFS_RISE, 32'h0);
    bus(1'b1, PEI_OFS_FALL, 32'h3F);
    pins(6'h3F);
    rc(PEI_OFS_FLAG, 32'h0);
    pins(6'h00);
    rc(PEI_OFS_FLAG, 32'h3F);
    bus(1'b1, PEI_OFS_RISE, 32'h3F);
    bus(1'b1, PEI_OFS_FLAG, 32'h0);
    pins(6'h20);
    rc(PEI_OFS_FLAG, 32'h20);
    bus(1'b1, PEI_OFS_FLAG, 32'h0);
    pins(6'h00);
    rc(PEI_OFS_FLAG, 32'h20);
    bus(1'b1, PEI_OFS_CTRL, 32'h1);
    chk("irq", 32'h1, irq);
    bus(1'b1, PEI_OFS_CTRL, 32'h0, 4'hE);
    chk("irq", 32'h1, irq);
    slp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("wake", 32'h1, wake);
    slp <= 1'b0;
    rc(PEI_OFS_STAT, 32'h3);
    bus(1'b1, PEI_OFS_FLAG, 32'h0);
    dbg <= 1'b1;
    pins(6'h03);
    rc(PEI_OFS_FLAG, 32'h0);
    chk("irq", 32'h0, irq);
    pins(6'h07);
    want <= 6'h03;
    repeat (4) @(posedge clk_i);
    bus(1'b1, PEI_OFS_FLAG, 32'h0);
    rc(PEI_OFS_FLAG, 32'h04);
    bus(1'b1, PEI_OFS_FLAG, 32'h0);
    ce <= 1'b0;
    pins(6'h3F);
    chk("sum", 32'h0, sum);
    ce <= 1'b1;
    repeat (8) @(posedge clk_i);
    rc(PEI_OFS_FLAG, 32'h3C);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) rc(ofs[i], 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
